/* core/rpc_irq.sv */
// sticky event status with enable mask and write-one clear
`timescale 1ns/1ps
module rpc_irq
	import rpc_pkg::*;
#(
	parameter int N = RPC_EV_N
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [N-1:0] event_in,
	input wire logic [N-1:0] clear_in,
	input wire logic enable_wr_in,
	input wire logic [N-1:0] enable_in,
	output logic [N-1:0] status_out,
	output logic [N-1:0] enable_out,
	output logic irq_out
);
	logic [N-1:0] next_status;
	logic [N-1:0] next_enable;

	// set wins over a clear in the same cycle
	always_comb begin
		next_status = (status_out & ~clear_in) | event_in;
		next_enable = enable_wr_in ? enable_in : enable_out;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_out <= '0;
			enable_out <= '0;
			irq_out <= 1'b0;
		end else begin
			status_out <= next_status;
			enable_out <= next_enable;
			irq_out <= |(next_status & next_enable);
		end
	end
endmodule // rpc_irq

/* core/rpc_pkg.sv */
// package for the rtc page control block: register map, fields, timing
package rpc_pkg;
	// register offsets (byte addresses, one word each)
	localparam logic [3:0] RPC_OFS_YEAR = 4'h0;
	localparam logic [3:0] RPC_OFS_PAGE = 4'h4;
	localparam logic [3:0] RPC_OFS_REST = 4'h8;
	localparam logic [3:0] RPC_OFS_SECS = 4'hC;
	localparam int RPC_ADDR_W = 4;
	// page and enable field positions
	localparam int RPC_PG_PAGE = 0;
	localparam int RPC_PG_ALARM = 2;
	localparam int RPC_PG_RUN = 3;
	localparam int RPC_PG_ROUND = 4;
	localparam int RPC_PG_IRQ = 7;
	// reset and tick select field positions
	localparam int RPC_RS_EIGHT = 0;
	localparam int RPC_RS_FOUR = 1;
	localparam int RPC_RS_TWO = 2;
	localparam int RPC_RS_ALMLD = 4;
	localparam int RPC_RS_SECCLR = 5;
	localparam int RPC_RS_SIXTEEN = 6;
	localparam int RPC_RS_ONE = 7;
	// leap field
	localparam int RPC_LEAP_W = 2;
	localparam logic [1:0] RPC_LEAP_RST = 2'h0;
	// reset value of the tick disables: all sources off
	localparam logic [4:0] RPC_TICKS_OFF = 5'h1F;
	// seconds handling
	localparam logic [5:0] RPC_SEC_HALF = 6'h1E;
	localparam logic [5:0] RPC_SEC_LAST = 6'h3B;
	localparam logic [5:0] RPC_MIN_LAST = 6'h3B;
	// alarm defaults: minute 00, hour 00, day 01, weekday sunday
	localparam logic [7:0] RPC_ALM_MIN_DEF = 8'h00;
	localparam logic [7:0] RPC_ALM_HOUR_DEF = 8'h00;
	localparam logic [7:0] RPC_ALM_DAY_DEF = 8'h01;
	localparam logic [2:0] RPC_ALM_WDAY_DEF = 3'h0;
	// low speed clock, and system clock rate
	localparam int RPC_SYS_HZ = 25000000;
	localparam int RPC_LS_HZ = 32768;
	localparam int RPC_LS_DIV = RPC_SYS_HZ / RPC_LS_HZ;
	localparam int RPC_LS_PER_SEC = RPC_LS_HZ;
	// irq status bits
	localparam int RPC_EV_TICK = 0;
	localparam int RPC_EV_ADJ = 1;
	localparam int RPC_EV_CLR = 2;
	localparam int RPC_EV_N = 3;
	localparam logic [3:0] RPC_OFS_IST = 4'h0;
	typedef enum logic [1:0] {RPC_SRC_ALARM, RPC_SRC_TICK, RPC_SRC_NONE} rpc_src_e;
endpackage

/* core/rpc_prescaler.sv */
// seconds prescaler: low speed enable divided into 1..16 Hz ticks
`timescale 1ns/1ps
module rpc_prescaler
	import rpc_pkg::*;
#(
	parameter int LS_DIV = RPC_LS_DIV,
	parameter int LS_PER_SEC = RPC_LS_PER_SEC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic clear_in,
	output logic ls_tick_out,
	output logic [4:0] rate_tick_out
);
	localparam int DW = $clog2(LS_DIV + 1);
	localparam int SW = $clog2(LS_PER_SEC);
	logic [DW-1:0] div_cnt;
	logic [DW-1:0] next_div_cnt;
	logic [SW-1:0] sec_cnt;
	logic [SW-1:0] next_sec_cnt;
	logic ls_en;
	logic [SW-1:0] sec_inc;

	// low speed rate from the system clock, free running so clears still sample
	always_comb begin
		ls_en = (div_cnt == DW'(LS_DIV - 1));
		next_div_cnt = ls_en ? '0 : div_cnt + DW'(1);
		sec_inc = sec_cnt + SW'(1);
		next_sec_cnt = sec_cnt;
		if (ls_en) begin
			if (clear_in) begin
				next_sec_cnt = '0;
			end else if (run_in) begin
				next_sec_cnt = sec_inc;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt <= '0;
			sec_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
			sec_cnt <= next_sec_cnt;
		end
	end

	// rate ticks: a rollover of the matching prescaler bit, bit 0 is 1 Hz
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_rate
			assign rate_tick_out[g] = ls_en && run_in && !clear_in &&
				(sec_cnt[SW-1-g:0] == {(SW-g){1'b1}});
		end
	endgenerate
	assign ls_tick_out = ls_en;
endmodule // rpc_prescaler

/* core/rpc_top.sv */
// rtc page control: leap field, page/enable, resets and tick select over avalon-mm
// Behaviour
// - two-bit leap field in year page 1
// - round request sampled at seconds increment only
// - seconds 0..29: clear seconds, minutes kept
// - seconds 30..59: carry minute, clear seconds
// - round bit reads one while pending
// - write one clears seconds prescaler, zero ignored
// - clear bit reads one while pending
// - alarm load sets 00:00, day 01, sunday
// - irq source alarm or exactly one tick
// - one second pulse from low speed prescaler
`timescale 1ns/1ps
module rpc_top
	import rpc_pkg::*;
#(
	parameter int LS_DIV = RPC_LS_DIV,
	parameter int LS_PER_SEC = RPC_LS_PER_SEC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [RPC_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic alarm_match_in,
	output logic calendar_page_out,
	output logic alarm_arm_out,
	output logic [7:0] alarm_minute_out,
	output logic [7:0] alarm_hour_out,
	output logic [7:0] alarm_day_out,
	output logic [2:0] alarm_weekday_out,
	output logic [5:0] seconds_out,
	output logic [5:0] minutes_out,
	output logic minute_carry_out,
	output logic clock_irq_out,
	output logic events_irq_out
);
	// control state
	logic [RPC_LEAP_W-1:0] leap_cycle, next_leap_cycle;
	logic page_sel, next_page_sel;
	logic alarm_enable, next_alarm_enable;
	logic count_run_enable, next_count_run_enable;
	logic irq_gate_enable, next_irq_gate_enable;
	logic second_round_request, next_second_round_request;
	logic second_counter_clear, next_second_counter_clear;
	logic tick_one_off, next_tick_one_off;
	logic tick_two_off, next_tick_two_off;
	logic tick_four_off, next_tick_four_off;
	logic tick_eight_off, next_tick_eight_off;
	logic tick_sixteen_off, next_tick_sixteen_off;
	logic [7:0] alm_min, next_alm_min;
	logic [7:0] alm_hour, next_alm_hour;
	logic [7:0] alm_day, next_alm_day;
	logic [2:0] alm_wday, next_alm_wday;
	logic [5:0] secs, next_secs;
	logic [5:0] mins, next_mins;
	logic carry, next_carry;
	logic clk_irq, next_clk_irq;
	// bus state
	logic [31:0] rdata, next_rdata;
	logic ack, next_ack;
	// wires
	logic wr, rd;
	logic ls_tick;
	logic [4:0] rate_tick;
	logic [4:0] offs;
	logic src_hit;
	logic [RPC_EV_N-1:0] ev, ev_clr, ev_stat, ev_en;
	logic ev_en_wr;
	logic irq_line;
	rpc_src_e src;

	// one wait cycle per access; ack drops the waitrequest for exactly one edge
	assign wr = avs_write_in && !ack && avs_byteenable_in[0];
	assign rd = avs_read_in && !ack;

	rpc_prescaler #(
		.LS_DIV(LS_DIV),
		.LS_PER_SEC(LS_PER_SEC)
	) u_pre (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(count_run_enable),
		.clear_in(second_counter_clear),
		.ls_tick_out(ls_tick),
		.rate_tick_out(rate_tick)
	);

	// tick disables packed as {16,8,4,2,1}; index 0 is the 1 Hz source
	assign offs = {tick_sixteen_off, tick_eight_off, tick_four_off, tick_two_off, tick_one_off};

	// source select: invalid combinations raise nothing
	always_comb begin
		src = RPC_SRC_NONE;
		src_hit = 1'b0;
		if (offs == RPC_TICKS_OFF && alarm_enable) begin
			src = RPC_SRC_ALARM;
			src_hit = alarm_match_in;
		end else if (!alarm_enable && $countones(~offs) == 1) begin
			src = RPC_SRC_TICK;
			src_hit = |(~offs & rate_tick);
		end
	end

	// event sources for the sticky status register
	always_comb begin
		ev = '0;
		ev[RPC_EV_TICK] = src_hit;
		ev[RPC_EV_ADJ] = second_round_request && rate_tick[0];
		ev[RPC_EV_CLR] = second_counter_clear && ls_tick;
		ev_clr = '0;
		ev_en_wr = 1'b0;
		if (wr && avs_address_in == RPC_OFS_IST) begin
			ev_clr = avs_writedata_in[RPC_EV_N+7:8];
		end
		if (wr && avs_address_in == RPC_OFS_SECS) begin
			ev_en_wr = 1'b1;
		end
	end

	rpc_irq #(
		.N(RPC_EV_N)
	) u_irq (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.event_in(ev),
		.clear_in(ev_clr),
		.enable_wr_in(ev_en_wr),
		.enable_in(avs_writedata_in[RPC_EV_N+7:8]),
		.status_out(ev_stat),
		.enable_out(ev_en),
		.irq_out(irq_line)
	);

	// register writes, request completion and the seconds/minutes counters
	always_comb begin
		next_leap_cycle = leap_cycle;
		next_page_sel = page_sel;
		next_alarm_enable = alarm_enable;
		next_count_run_enable = count_run_enable;
		next_irq_gate_enable = irq_gate_enable;
		next_second_round_request = second_round_request;
		next_second_counter_clear = second_counter_clear;
		next_tick_one_off = tick_one_off;
		next_tick_two_off = tick_two_off;
		next_tick_four_off = tick_four_off;
		next_tick_eight_off = tick_eight_off;
		next_tick_sixteen_off = tick_sixteen_off;
		next_alm_min = alm_min;
		next_alm_hour = alm_hour;
		next_alm_day = alm_day;
		next_alm_wday = alm_wday;
		next_secs = secs;
		next_mins = mins;
		next_carry = 1'b0;
		// seconds step; round request taken only here
		if (second_counter_clear && ls_tick) begin
			next_secs = '0;
			next_second_counter_clear = 1'b0;
		end else if (rate_tick[0]) begin
			if (second_round_request) begin
				next_second_round_request = 1'b0;
				next_secs = '0;
				if (secs >= RPC_SEC_HALF) begin
					next_carry = 1'b1;
				end
			end else if (secs == RPC_SEC_LAST) begin
				next_secs = '0;
				next_carry = 1'b1;
			end else begin
				next_secs = secs + 6'h01;
			end
		end
		if (next_carry) begin
			next_mins = (mins == RPC_MIN_LAST) ? 6'h00 : mins + 6'h01;
		end
		// writes; a set request is sticky until hardware finishes it
		if (wr && avs_address_in == RPC_OFS_YEAR && page_sel) begin
			next_leap_cycle = avs_writedata_in[RPC_LEAP_W-1:0];
		end else if (wr && avs_address_in == RPC_OFS_PAGE) begin
			next_page_sel = avs_writedata_in[RPC_PG_PAGE];
			next_alarm_enable = avs_writedata_in[RPC_PG_ALARM];
			next_count_run_enable = avs_writedata_in[RPC_PG_RUN];
			next_irq_gate_enable = avs_writedata_in[RPC_PG_IRQ];
			if (avs_writedata_in[RPC_PG_ROUND]) begin
				next_second_round_request = 1'b1;
			end
		end else if (wr && avs_address_in == RPC_OFS_REST) begin
			next_tick_one_off = avs_writedata_in[RPC_RS_ONE];
			next_tick_two_off = avs_writedata_in[RPC_RS_TWO];
			next_tick_four_off = avs_writedata_in[RPC_RS_FOUR];
			next_tick_eight_off = avs_writedata_in[RPC_RS_EIGHT];
			next_tick_sixteen_off = avs_writedata_in[RPC_RS_SIXTEEN];
			if (avs_writedata_in[RPC_RS_SECCLR]) begin
				next_second_counter_clear = 1'b1;
			end
			if (avs_writedata_in[RPC_RS_ALMLD]) begin
				next_alm_min = RPC_ALM_MIN_DEF;
				next_alm_hour = RPC_ALM_HOUR_DEF;
				next_alm_day = RPC_ALM_DAY_DEF;
				next_alm_wday = RPC_ALM_WDAY_DEF;
			end
		end
		// rtc line: selected source, gated by the enable bit
		next_clk_irq = src_hit && irq_gate_enable;
	end

	// read mux; status shown in request bits, so a readback is not the written value
	always_comb begin
		next_ack = (avs_read_in || avs_write_in) && !ack;
		next_rdata = rdata;
		if (rd) begin
			next_rdata = '0;
			if (avs_address_in == RPC_OFS_YEAR) begin
				if (page_sel) begin
					next_rdata[RPC_LEAP_W-1:0] = leap_cycle;
				end
			end else if (avs_address_in == RPC_OFS_PAGE) begin
				next_rdata[RPC_PG_PAGE] = page_sel;
				next_rdata[RPC_PG_ALARM] = alarm_enable;
				next_rdata[RPC_PG_RUN] = count_run_enable;
				next_rdata[RPC_PG_ROUND] = second_round_request;
				next_rdata[RPC_PG_IRQ] = irq_gate_enable;
			end else if (avs_address_in == RPC_OFS_REST) begin
				next_rdata[RPC_RS_ONE] = tick_one_off;
				next_rdata[RPC_RS_TWO] = tick_two_off;
				next_rdata[RPC_RS_FOUR] = tick_four_off;
				next_rdata[RPC_RS_EIGHT] = tick_eight_off;
				next_rdata[RPC_RS_SIXTEEN] = tick_sixteen_off;
				next_rdata[RPC_RS_SECCLR] = second_counter_clear;
			end else if (avs_address_in == RPC_OFS_SECS) begin
				next_rdata[5:0] = secs;
				next_rdata[RPC_EV_N+7:8] = ev_en;
				next_rdata[RPC_EV_N+15:16] = ev_stat;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			leap_cycle <= RPC_LEAP_RST;
			page_sel <= 1'b0;
			alarm_enable <= 1'b0;
			count_run_enable <= 1'b0;
			irq_gate_enable <= 1'b0;
			second_round_request <= 1'b0;
			second_counter_clear <= 1'b0;
			tick_one_off <= 1'b1;
			tick_two_off <= 1'b1;
			tick_four_off <= 1'b1;
			tick_eight_off <= 1'b1;
			tick_sixteen_off <= 1'b1;
			alm_min <= RPC_ALM_MIN_DEF;
			alm_hour <= RPC_ALM_HOUR_DEF;
			alm_day <= RPC_ALM_DAY_DEF;
			alm_wday <= RPC_ALM_WDAY_DEF;
			secs <= '0;
			mins <= '0;
			carry <= 1'b0;
			clk_irq <= 1'b0;
			rdata <= '0;
			ack <= 1'b0;
		end else begin
			leap_cycle <= next_leap_cycle;
			page_sel <= next_page_sel;
			alarm_enable <= next_alarm_enable;
			count_run_enable <= next_count_run_enable;
			irq_gate_enable <= next_irq_gate_enable;
			second_round_request <= next_second_round_request;
			second_counter_clear <= next_second_counter_clear;
			tick_one_off <= next_tick_one_off;
			tick_two_off <= next_tick_two_off;
			tick_four_off <= next_tick_four_off;
			tick_eight_off <= next_tick_eight_off;
			tick_sixteen_off <= next_tick_sixteen_off;
			alm_min <= next_alm_min;
			alm_hour <= next_alm_hour;
			alm_day <= next_alm_day;
			alm_wday <= next_alm_wday;
			secs <= next_secs;
			mins <= next_mins;
			carry <= next_carry;
			clk_irq <= next_clk_irq;
			rdata <= next_rdata;
			ack <= next_ack;
		end
	end

	// outputs straight from flip-flops
	assign avs_readdata_out = rdata;
	assign avs_waitrequest_out = !ack;
	assign calendar_page_out = page_sel;
	assign alarm_arm_out = alarm_enable;
	assign alarm_minute_out = alm_min;
	assign alarm_hour_out = alm_hour;
	assign alarm_day_out = alm_day;
	assign alarm_weekday_out = alm_wday;
	assign seconds_out = secs;
	assign minutes_out = mins;
	assign minute_carry_out = carry;
	assign clock_irq_out = clk_irq;
	assign events_irq_out = irq_line;
endmodule // rpc_top

/* verification/rpc_top_properties.sv */
// checker for bus handshake and seconds and minutes counting of rpc_top
`timescale 1ns/1ps
module rpc_top_properties
	import rpc_pkg::*;
#(
	parameter int LS_DIV = RPC_LS_DIV,
	parameter int LS_PER_SEC = RPC_LS_PER_SEC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic [5:0] seconds_out,
	input wire logic [5:0] minutes_out,
	input wire logic minute_carry_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// one answer per request, never unprompted
	bus_ack_once_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low twice in a row");
	bus_ack_cause_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
		else $error("answer without request");
	rdata_hold_a: assert property (!avs_read_in && !$past(avs_read_in) |-> $stable(avs_readdata_out))
		else $error("read data moved without read");
	secs_range_a: assert property (seconds_out <= RPC_SEC_LAST)
		else $error("seconds beyond last");
	// seconds only step by one or drop to zero
	secs_step_a: assert property ($changed(seconds_out) |->
		seconds_out == 6'h00 || seconds_out == $past(seconds_out) + 6'h01)
		else $error("seconds jumped");
	mins_step_a: assert property ($changed(minutes_out) |-> minutes_out ==
		(($past(minutes_out) == RPC_MIN_LAST) ? 6'h00 : $past(minutes_out) + 6'h01))
		else $error("minutes jumped");
	carry_pulse_a: assert property (minute_carry_out |=> !minute_carry_out)
		else $error("carry held");
	// a drop to zero from below the half minute keeps the minutes
	low_round_a: assert property ($changed(seconds_out) && seconds_out == 6'h00 &&
		$past(seconds_out) < RPC_SEC_HALF |-> $stable(minutes_out))
		else $error("minutes moved on low round");
endmodule // rpc_top_properties
bind rpc_top rpc_top_properties #(.LS_DIV(LS_DIV), .LS_PER_SEC(LS_PER_SEC)) u_props (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .seconds_out(seconds_out),
	.minutes_out(minutes_out), .minute_carry_out(minute_carry_out));

/* verification/rpc_top_tb_top.sv */
// register level testbench for rpc_top
`timescale 1ns/1ps
module rpc_top_tb_top import rpc_pkg::*;;
	logic ref_clk_in, rst_n_in, avs_read_in, avs_write_in, alarm_match_in;
	logic [3:0] avs_address_in, avs_byteenable_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, q;
	logic avs_waitrequest_out, calendar_page_out, alarm_arm_out, minute_carry_out;
	logic clock_irq_out, events_irq_out, irq_seen;
	logic [7:0] alarm_minute_out, alarm_hour_out, alarm_day_out;
	logic [2:0] alarm_weekday_out;
	logic [5:0] seconds_out, minutes_out, m0;
	int error_cnt, checks, cyc, i, irq_cnt;
	int pos [5] = '{RPC_RS_ONE, RPC_RS_TWO, RPC_RS_FOUR, RPC_RS_EIGHT, RPC_RS_SIXTEEN};
	// short counts keep one second at 64 clocks
	rpc_top #(.LS_DIV(2), .LS_PER_SEC(32)) dut (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.alarm_match_in(alarm_match_in), .calendar_page_out(calendar_page_out),
		.alarm_arm_out(alarm_arm_out), .alarm_minute_out(alarm_minute_out),
		.alarm_hour_out(alarm_hour_out), .alarm_day_out(alarm_day_out),
		.alarm_weekday_out(alarm_weekday_out), .seconds_out(seconds_out),
		.minutes_out(minutes_out), .minute_carry_out(minute_carry_out),
		.clock_irq_out(clock_irq_out), .events_irq_out(events_irq_out));
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	task complete_run;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// hang guard and irq pulse catcher
	always @(posedge ref_clk_in) begin
		cyc++;
		if (clock_irq_out === 1'b1) irq_seen = 1'b1;
		if (cyc == 30000) begin
			error_cnt++;
			complete_run;
		end
	end
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one bus cycle; held until waitrequest low, then one idle edge
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge ref_clk_in);
		// no wait limit here; the cycle ceiling ends a hung slave
		while (avs_waitrequest_out !== 1'b0) begin
			@(posedge ref_clk_in);
		end
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hF);
	endtask
	task rdc(input string nm, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, 32'h0, 4'hF);
		cmp(nm, e, q & m);
	endtask
	task waitsec(input logic [5:0] v);
		int n;
		n = 0;
		while (seconds_out !== v && n < 5000) begin
			@(posedge ref_clk_in);
			n++;
		end
		if (n == 5000) error_cnt++;
	endtask
	// alarm comparator hit, irq outcome judged by caller
	task hit;
		irq_seen = 1'b0;
		alarm_match_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		alarm_match_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask
	// clock_irq pulses over one second of clocks (64 with the short counts)
	task count_irq;
		irq_cnt = 0;
		repeat (64) begin
			@(posedge ref_clk_in);
			if (clock_irq_out === 1'b1) irq_cnt++;
		end
	endtask
	task chk_alarm;
		cmp("alarm", {alarm_minute_out, alarm_hour_out, alarm_day_out, 5'h00, alarm_weekday_out},
			{RPC_ALM_MIN_DEF, RPC_ALM_HOUR_DEF, RPC_ALM_DAY_DEF, 5'h00, RPC_ALM_WDAY_DEF});
	endtask
	initial begin
		{rst_n_in, avs_read_in, avs_write_in, alarm_match_in, irq_seen} = 5'h00;
		{avs_address_in, avs_byteenable_in, avs_writedata_in} = 40'h0;
		repeat (6) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(posedge ref_clk_in);
		rdc("page_rst", RPC_OFS_PAGE, 32'h00, 32'hFF);
		rdc("tick_rst", RPC_OFS_REST, 32'hC7, 32'hFF);
		chk_alarm;
		wr(RPC_OFS_PAGE, 32'h01);
		cmp("page_out", 32'h1, calendar_page_out);
		for (i = 0; i < 4; i++) begin
			wr(RPC_OFS_YEAR, i);
			rdc("leap", RPC_OFS_YEAR, i, 32'hFF);
		end
		acc(1'b1, RPC_OFS_PAGE, 32'h00, 4'h0);
		rdc("be_drop", RPC_OFS_PAGE, 32'h01, 32'hFF);
		wr(RPC_OFS_PAGE, 32'h00);
		rdc("leap_p0", RPC_OFS_YEAR, 32'h0, 32'h3);
		rdc("unmapped", 4'h2, 32'h0, 32'hFFFFFFFF);
		for (i = 0; i < 5; i++) begin
			wr(RPC_OFS_REST, 32'hC7 & ~(32'h1 << pos[i]));
			rdc("tick_off", RPC_OFS_REST, 32'hC7 & ~(32'h1 << pos[i]), 32'hFF);
		end
		wr(RPC_OFS_REST, 32'hD7);
		chk_alarm;
		// run and alarm first, gate later; gate off must block irq
		wr(RPC_OFS_PAGE, 32'h0C);
		cmp("arm", 32'h1, alarm_arm_out);
		wr(RPC_OFS_SECS, 32'h000);
		wr(RPC_OFS_YEAR, 32'h700);
		hit;
		cmp("irq_gated", 32'h0, irq_seen);
		wr(RPC_OFS_PAGE, 32'h8C);
		rdc("page_en", RPC_OFS_PAGE, 32'h8C, 32'hFF);
		hit;
		cmp("irq_alarm", 32'h1, irq_seen);
		rdc("ev_hit", RPC_OFS_SECS, 32'h10000, 32'h70700);
		cmp("ev_mask", 32'h0, events_irq_out);
		wr(RPC_OFS_SECS, 32'h100);
		cmp("ev_irq", 32'h1, events_irq_out);
		wr(RPC_OFS_YEAR, 32'h100);
		cmp("ev_clr", 32'h0, events_irq_out);
		// seconds clear request completes and reports
		wr(RPC_OFS_REST, 32'hE7);
		repeat (8) @(posedge ref_clk_in);
		rdc("clr_done", RPC_OFS_REST, 32'hC7, 32'hFF);
		rdc("ev_secclr", RPC_OFS_SECS, 32'h40000, 32'h40000);
		// round below and above the half minute
		waitsec(6'h05);
		m0 = minutes_out;
		wr(RPC_OFS_PAGE, 32'h9C);
		rdc("round_pend", RPC_OFS_PAGE, 32'h10, 32'h10);
		cmp("round_late", 32'h5, seconds_out);
		waitsec(6'h00);
		cmp("min_kept", m0, minutes_out);
		rdc("round_done", RPC_OFS_PAGE, 32'h00, 32'h10);
		rdc("ev_round", RPC_OFS_SECS, 32'h20000, 32'h20000);
		waitsec(6'h1F);
		wr(RPC_OFS_PAGE, 32'h9C);
		waitsec(6'h00);
		cmp("min_carry", m0 + 6'h01, minutes_out);
		// periodic sources: gate off before the first enable write, gate back on after it
		wr(RPC_OFS_PAGE, 32'h0C);
		wr(RPC_OFS_PAGE, 32'h08);
		wr(RPC_OFS_REST, 32'h47);
		wr(RPC_OFS_PAGE, 32'h88);
		count_irq;
		cmp("irq_1hz", 32'h1, irq_cnt);
		wr(RPC_OFS_REST, 32'h87);
		count_irq;
		cmp("irq_16hz", 32'h10, irq_cnt);
		// two sources at once is not a valid selection: nothing raised
		wr(RPC_OFS_REST, 32'h07);
		count_irq;
		cmp("irq_invalid", 32'h0, irq_cnt);
		complete_run;
	end
endmodule // rpc_top_tb_top
